// ==== logic/spl_consts.svh ====
// Constants for the serial wiper latch controller.
`ifndef SPL_CONSTS_SVH
`define SPL_CONSTS_SVH
`define SPL_DATA_W 8
`define SPL_WORD_W 9
`define SPL_ADDR_BIT 8
`define SPL_MID_SCALE 8'h80
`define SPL_OUT_TAP 7
`define SPL_SHREG_RST 9'h000
`define SPL_COUT_RST 1'b0
`define SPL_PIN_RST 1'b1
`define SPL_UNUSED_LATCH 8'h00
`define SPL_DRIVE_LOW 1'b0
`endif

// ==== logic/spl_pkg.sv ====
// Types for the serial wiper latch controller.
package spl_pkg;
  typedef struct packed {
    logic [8:0] shreg;
    logic [7:0] wiper0;
    logic [7:0] wiper1;
    logic cout;
    logic sclk_d;
    logic cs_d;
    logic pr_d;
  } spl_state_t;
endpackage

// ==== logic/spl_sync.sv ====
// Two-flop synchroniser for a group of pins.
`timescale 1ns/100ps
`include "spl_consts.svh"
module spl_sync #(
  parameter int W = 4
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] q_nxt;
  // Every pin resets high, the idle level of select, preset and power-down; the serial clock then only falls, which is harmless.
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          s1_r[i] <= `SPL_PIN_RST;
          q[i] <= `SPL_PIN_RST;
        end
        else
        begin
          s1_r[i] <= s1_nxt[i];
          q[i] <= q_nxt[i];
        end
      end
    end
  endgenerate
  always_comb
  begin
    s1_nxt = d;
    q_nxt = s1_r;
  end
endmodule // spl_sync

// ==== logic/spl_ctrl.sv ====
// Serial input, cascade output and wiper latch control of the potentiometer.
`timescale 1ns/100ps
`include "spl_consts.svh"
module spl_ctrl #(
  parameter bit DUAL = 1'b1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  input wire logic preset_n,
  input wire logic power_down_n,
  output logic [7:0] wiper_code_latch0,
  output logic [7:0] wiper_code_latch1,
  output logic terminal_a_open,
  output logic wiper_to_b,
  output logic cascade_out_o,
  output logic cascade_out_oe
);
  spl_pkg::spl_state_t st_r;
  spl_pkg::spl_state_t st_nxt;
  logic [4:0] pins;
  logic sclk_s;
  logic cs_s;
  logic sdi_s;
  logic pr_s;
  logic pd_s;
  logic shift_ev;
  logic load_ev;
  logic pr_rise;
  logic word_addr;
  logic [`SPL_DATA_W-1:0] word_data;
  logic load_ch0;
  logic load_ch1;

  spl_sync #(.W(5)) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .d({sclk, cs_n, serial_in, preset_n, power_down_n}),
    .q(pins)
  );
  assign {sclk_s, cs_s, sdi_s, pr_s, pd_s} = pins;

  assign shift_ev = sclk_s && !st_r.sclk_d && !cs_s;
  assign load_ev = cs_s && !st_r.cs_d;
  assign pr_rise = pr_s && !st_r.pr_d && cs_s;
  assign word_addr = st_r.shreg[`SPL_ADDR_BIT];
  assign word_data = st_r.shreg[`SPL_DATA_W-1:0];
  // A single-channel part ignores the address bit and always loads its only latch.
  assign load_ch0 = load_ev && (!DUAL || !word_addr);
  assign load_ch1 = load_ev && DUAL && word_addr;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sclk_d = sclk_s;
    st_nxt.cs_d = cs_s;
    st_nxt.pr_d = pr_s;
    if (shift_ev)
    begin
      // Newest bit enters at the bottom, so the first bit sent ends on top.
      st_nxt.shreg = {st_r.shreg[`SPL_WORD_W-2:0], sdi_s};
      st_nxt.cout = st_r.shreg[`SPL_OUT_TAP];
    end
    if (load_ch0)
    begin
      st_nxt.wiper0 = word_data;
    end
    if (load_ch1)
    begin
      st_nxt.wiper1 = word_data;
    end
    if (pr_rise)
    begin
      st_nxt.wiper0 = `SPL_MID_SCALE;
      st_nxt.wiper1 = `SPL_MID_SCALE;
    end
    // Preset is applied last so it wins any collision with a load.
    if (!pr_s)
    begin
      st_nxt.wiper0 = `SPL_MID_SCALE;
      st_nxt.wiper1 = `SPL_MID_SCALE;
      st_nxt.cout = `SPL_COUT_RST;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= '{
        shreg: `SPL_SHREG_RST,
        wiper0: `SPL_MID_SCALE,
        wiper1: `SPL_MID_SCALE,
        cout: `SPL_COUT_RST,
        sclk_d: `SPL_PIN_RST,
        cs_d: `SPL_PIN_RST,
        pr_d: `SPL_PIN_RST
      };
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign wiper_code_latch0 = st_r.wiper0;
  assign wiper_code_latch1 = DUAL ? st_r.wiper1 : `SPL_UNUSED_LATCH;
  assign terminal_a_open = !pd_s;
  assign wiper_to_b = !pd_s;
  // Open drain: drive only a low, never while powered down.
  assign cascade_out_o = `SPL_DRIVE_LOW;
  assign cascade_out_oe = pd_s && !st_r.cout;

  sequence s_clk_idle;
    !sclk_s && !st_r.sclk_d;
  endsequence

  sequence s_pin_clock_rise;
    $rose(sclk) && !cs_n;
  endsequence

  sequence s_pin_select_rise;
    $rose(cs_n);
  endsequence

  sequence s_pin_preset_rise;
    $rose(preset_n) && cs_n;
  endsequence

  sequence s_shift_free;
    shift_ev && pr_s;
  endsequence

  sequence s_load0;
    load_ch0 && pr_s && !pr_rise;
  endsequence

  sequence s_load1;
    load_ch1 && pr_s && !pr_rise;
  endsequence

  sequence s_quiet;
    pr_s && !load_ev && !pr_rise;
  endsequence

  sequence s_pd_quiet;
    !pd_s && pr_s && !load_ev && !pr_rise;
  endsequence

  a_shift_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_clk_idle
    |=> $stable(st_r.shreg))
    else $error("shift register moved without clock edge");

  a_shift_in: assert property (@(posedge ref_clk) disable iff (!reset_n)
    shift_ev
    |=> st_r.shreg[0] == $past(sdi_s))
    else $error("serial bit not shifted in");

  a_shift_move: assert property (@(posedge ref_clk) disable iff (!reset_n)
    shift_ev
    |=> st_r.shreg[`SPL_WORD_W-1:1] == $past(st_r.shreg[`SPL_WORD_W-2:0]))
    else $error("shift register did not advance by one place");

  a_clock_seen: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_pin_clock_rise
    |-> ##2 shift_ev)
    else $error("serial clock rise not taken");

  a_cascade_tap: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_shift_free
    |=> st_r.cout == $past(st_r.shreg[`SPL_OUT_TAP]))
    else $error("cascade output wrong bit");

  a_cascade_keep: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!shift_ev && pr_s)
    |=> $stable(st_r.cout))
    else $error("cascade output moved without shift");

  a_out_enable: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (pd_s && !cs_s && !sclk_s)
    |-> (cascade_out_oe == !st_r.cout))
    else $error("cascade output not enabled while idle");

  a_select_seen: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_pin_select_rise
    |-> ##2 load_ev)
    else $error("select rise not taken");

  a_select_high: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cs_s && st_r.cs_d)
    |=> $stable(st_r.shreg))
    else $error("shift register moved while deselected");

  a_load_ch0: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_load0
    |=> st_r.wiper0 == $past(word_data))
    else $error("first latch not loaded");

  a_load_ch1: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_load1
    |=> st_r.wiper1 == $past(word_data))
    else $error("second latch not loaded");

  a_single_load: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!DUAL && load_ev && pr_s && !pr_rise)
    |=> st_r.wiper0 == $past(word_data))
    else $error("single latch not loaded");

  a_one_channel: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (load_ev && pr_s && !pr_rise)
    |=> ($stable(st_r.wiper0) || $stable(st_r.wiper1)))
    else $error("one frame changed both latches");

  a_load_other: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_load0
    |=> $stable(st_r.wiper1))
    else $error("other latch disturbed");

  a_load_keep: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_load1
    |=> $stable(st_r.wiper0))
    else $error("first latch disturbed");

  a_idle_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_quiet
    |=> $stable(st_r.wiper0))
    else $error("latch changed without load");

  a_idle_other: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_quiet
    |=> $stable(st_r.wiper1))
    else $error("second latch changed without load");

  a_preset_mid: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !pr_s
    |=> (st_r.wiper0 == `SPL_MID_SCALE && st_r.wiper1 == `SPL_MID_SCALE && !st_r.cout))
    else $error("preset did not force mid-scale");

  a_preset_pin: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !preset_n
    |-> ##3 (st_r.wiper0 == `SPL_MID_SCALE && st_r.wiper1 == `SPL_MID_SCALE && !st_r.cout))
    else $error("preset pin not applied in time");

  a_preset_seen: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_pin_preset_rise
    |-> ##2 pr_rise)
    else $error("preset release not taken");

  a_preset_load: assert property (@(posedge ref_clk) disable iff (!reset_n)
    pr_rise
    |=> (st_r.wiper0 == `SPL_MID_SCALE && st_r.wiper1 == `SPL_MID_SCALE))
    else $error("preset release did not load mid-scale");

  a_preset_wins: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!pr_s && load_ev)
    |=> (st_r.wiper0 == `SPL_MID_SCALE && st_r.wiper1 == `SPL_MID_SCALE))
    else $error("load won over preset");

  a_power_up: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(reset_n)
    |-> (st_r.wiper0 == `SPL_MID_SCALE && st_r.wiper1 == `SPL_MID_SCALE))
    else $error("latches not at mid-scale after power-up");

  a_pd_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !pd_s
    |-> (!cascade_out_oe && terminal_a_open && wiper_to_b))
    else $error("power-down outputs wrong");

  a_pd_seen: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(power_down_n)
    |-> ##2 (terminal_a_open && wiper_to_b && !cascade_out_oe))
    else $error("power-down not taken in time");

  a_pd_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(power_down_n)
    |-> ##2 (!terminal_a_open && !wiper_to_b))
    else $error("power-down not left in time");

  a_pd_keep: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_pd_quiet
    |=> ($stable(st_r.wiper0) && $stable(st_r.wiper1)))
    else $error("power-down changed a latch");
endmodule // spl_ctrl

// ==== verif/spl_host.sv ====
// Host model that drives the three-wire serial bus.
`timescale 1ns/100ps
module spl_host (
  output logic sclk,
  output logic cs_n,
  output logic serial_in
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
  end
  // Clock rests low between frames; data flips after release so no stale bit lingers.
  task automatic send(input logic [17:0] w, input int n);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in = w[i];
      #400 sclk = 1'b1;
      #400 sclk = 1'b0;
    end
    #400 cs_n = 1'b1;
    serial_in = ~serial_in;
  endtask
endmodule // spl_host

// ==== verif/serial_pot_latch_ctrl_tb_top.sv ====
// Self-checking bench for the wiper latch controller.
`timescale 1ns/100ps
module serial_pot_latch_ctrl_tb_top;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic preset_n = 1'b1;
  logic power_down_n = 1'b1;
  logic sclk, cs_n, serial_in, a_open, to_b, c_o, c_oe;
  logic [7:0] w0, w1;
  logic [7:0] s0;
  int n_errors = 0;
  int checked = 0;
  // Open drain with pull-up: the pin reads high unless pulled low.
  wire pin = c_oe ? c_o : 1'b1;
  always #50 ref_clk = ~ref_clk;
  spl_host u_spl_host (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in));
  spl_ctrl u_spl_ctrl (.ref_clk(ref_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
    .serial_in(serial_in), .preset_n(preset_n), .power_down_n(power_down_n),
    .wiper_code_latch0(w0), .wiper_code_latch1(w1), .terminal_a_open(a_open),
    .wiper_to_b(to_b), .cascade_out_o(c_o), .cascade_out_oe(c_oe));
  spl_ctrl #(.DUAL(1'b0)) u_spl_ctrl_1ch (.ref_clk(ref_clk), .reset_n(reset_n), .sclk(sclk),
    .cs_n(cs_n), .serial_in(serial_in), .preset_n(preset_n), .power_down_n(power_down_n),
    .wiper_code_latch0(s0), .wiper_code_latch1(), .terminal_a_open(), .wiper_to_b(),
    .cascade_out_o(), .cascade_out_oe());
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (10) @(posedge ref_clk);
    #1;
  endtask
  task automatic t_write();
    u_spl_host.send({9'h0, 9'h0a5}, 9);
    settle();
    check(w0, 8'ha5);
    check(w1, 8'h80);
    check(s0, 8'ha5);
    check({7'h0, pin}, 8'h00);
  endtask
  task automatic t_surplus();
    u_spl_host.send(18'hb3c, 12);
    settle();
    check(w1, 8'h3c);
    check(w0, 8'ha5);
    check(s0, 8'h3c);
    check({7'h0, pin}, 8'h01);
  endtask
  task automatic t_power_down();
    u_spl_host.send(18'h0a5, 9);
    settle();
    check({7'h0, pin}, 8'h00);
    power_down_n = 1'b0;
    settle();
    check({5'h0, a_open, to_b, pin}, 8'h07);
    check(w0, 8'ha5);
    check(w1, 8'h3c);
    power_down_n = 1'b1;
    settle();
    check({6'h0, a_open, pin}, 8'h00);
    check(w1, 8'h3c);
  endtask
  task automatic t_preset();
    u_spl_host.send(18'h1c3, 9);
    settle();
    check(w1, 8'hc3);
    check({7'h0, pin}, 8'h01);
    preset_n = 1'b0;
    settle();
    check(w1, 8'h80);
    check({7'h0, pin}, 8'h00);
    u_spl_host.send(18'h011, 9);
    settle();
    check(w0, 8'h80);
    check(s0, 8'h80);
    preset_n = 1'b1;
    settle();
    check(w0, 8'h80);
    check(w1, 8'h80);
  endtask
  task automatic results();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    settle();
    check(w0, 8'h80);
    t_write();
    t_surplus();
    t_power_down();
    t_preset();
    results();
  end
endmodule // serial_pot_latch_ctrl_tb_top
